// >>> pkg/timer_defines.svh
/*
  Offsets, field reset values, mode codes and clock-source codes for the
  pulse width and pattern retrigger timer.
  Assumes an 8-bit register port with a 4-bit word address.
*/
`ifndef TIMER_DEFINES_SVH
`define TIMER_DEFINES_SVH

// ---------------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------------
`define OFS_PRESCALER_CONTROL  4'h0
`define OFS_COUNTER0_CONTROL   4'h1
`define OFS_COUNTER1_CONTROL   4'h2
`define OFS_COUNTER2_CONTROL   4'h3
`define OFS_COUNTER3_CONTROL_A 4'h4
`define OFS_COUNTER3_CONTROL_B 4'h5
`define OFS_COUNTER0_COUNT     4'h6
`define OFS_COUNTER1_COUNT     4'h7
`define OFS_COUNTER2_COUNT     4'h8
`define OFS_COUNTER3_COUNT     4'h9
`define OFS_REQUEST_ENABLE     4'hA
`define OFS_STATUS             4'hB

// ---------------------------------------------------------------------
// field positions and reset values
// ---------------------------------------------------------------------
`define POS_RESTART_ENABLE     0
`define RST_CONTROL            8'h00
`define RST_CONTROL_B          8'h00
`define RST_PRESCALER          8'h00
`define RST_REQUEST_ENABLE     8'h00
`define RST_COUNT              8'h00

// ---------------------------------------------------------------------
// operating mode codes
// ---------------------------------------------------------------------
`define OP_PULSE_GEN           2'h0
`define OP_EVENT               2'h1
`define OP_TIMER               2'h2
`define OP_WIDTH               2'h3

// ---------------------------------------------------------------------
// prescaler source codes
// ---------------------------------------------------------------------
`define SRC_SYS                2'h0
`define SRC_SYS_DIV4           2'h1
`define SRC_SYS_DIV2           2'h2
`define SRC_SUB                2'h3

// ---------------------------------------------------------------------
// synchroniser lanes
// ---------------------------------------------------------------------
`define SYN_PIN0               0
`define SYN_PIN1               1
`define SYN_CMP_LEVEL          2
`define SYN_CMP_PULSE          3
`define SYN_SUB_CLOCK          4
`define SYN_PAT_ACTIVE         5
`define SYN_PAT_DISABLE        6
`define SYN_PAT_STOPPED        7
`define SYN_LANES              8

`define COUNT_MAX              8'hFF

`endif

// >>> pkg/timer_pkg.sv
/*
  Types shared by the timer design files.
  Assumes timer_defines.svh is on the include path.
*/
`include "timer_defines.svh"

package timer_pkg;

  typedef struct packed {
    logic [1:0] op_select;
    logic       external_source_select;
    logic       counter_run_enable;
    logic       active_edge_select;
    logic [2:0] counter_prescale_ratio;
  } counter_control_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       write;
    logic       read;
  } reg_req_t;

  typedef struct packed {
    logic timer0_ext_input_pin;
    logic timer1_ext_input_pin;
    logic comparator0_level_output;
    logic comparator0_pulse_event;
    logic sub_clock;
    logic pattern_output_activation;
    logic pattern_output_disable;
    logic pattern_stopped;
  } ext_inputs_t;

  typedef enum logic {
    MEAS_ARMED,
    MEAS_RUNNING
  } meas_state_t;

endpackage

// >>> hdl/prescale_divider.sv
/*
  Per-counter prescaler: divides the prescaler input clock ticks by 2**ratio.
  Assumes i_source_tick is a one-cycle pulse on i_clock.
*/
`timescale 1ns/100ps
`default_nettype none

module prescale_divider
  import timer_pkg::*;
#(
  parameter int DIV_BITS = 7
) (
  input  wire logic       i_clock,
  input  wire logic       i_rst_n,
  input  wire logic       i_source_tick,
  input  wire logic [2:0] i_ratio,
  output logic            o_tick
);

  logic [DIV_BITS-1:0] div_count;
  logic [DIV_BITS-1:0] mask;

  // ---------------------------------------------------------------------
  // ratio decode
  // ---------------------------------------------------------------------
  function automatic logic [DIV_BITS-1:0] ratio_mask(input logic [2:0] ratio);
    logic [DIV_BITS:0] one_hot;
    one_hot = (DIV_BITS+1)'(1) << ratio;
    return DIV_BITS'(one_hot - (DIV_BITS+1)'(1));
  endfunction

  assign mask   = ratio_mask(i_ratio);
  assign o_tick = i_source_tick && ((div_count & mask) == mask);

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      div_count <= '0;
    end else if (i_source_tick) begin
      div_count <= div_count + DIV_BITS'(1);
    end
  end

endmodule

`default_nettype wire

// >>> hdl/pulse_width_and_pattern_retrigger_timer.sv
/*
  Four 8-bit timer counters with event counting and pulse width measurement on counters
  0, 1 and 3, pattern non-retrigger mode on counter 2 and pattern retrigger
  mode on counter 3, behind a plain 8-bit register port.
  Assumes all i_ext inputs are asynchronous; the register port is on i_clock.
*/
`timescale 1ns/100ps
`default_nettype none

module pulse_width_and_pattern_retrigger_timer
  import timer_pkg::*;
#(
  parameter int COUNTERS = 4
) (
  input  wire logic        i_clock,
  input  wire logic        i_rst_n,
  input  wire reg_req_t    i_reg_req,
  output logic [7:0]       o_read_data,
  input  wire ext_inputs_t i_ext,
  output logic             o_pattern_retrigger_pulse,
  output logic [3:0]       o_overflow_request,
  output logic [3:0]       o_timer_request
);

  // ---------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------
  counter_control_t        ctrl       [COUNTERS];
  logic [7:0]              count      [COUNTERS];
  logic [7:0]              preload    [COUNTERS];
  meas_state_t             meas       [COUNTERS];
  logic                    wprev      [COUNTERS];
  logic [7:0]              prescaler_control;
  logic [7:0]              counter3_control_b;
  logic [3:0]              request_enable;
  logic [`SYN_LANES-1:0]   sync_a;
  logic [`SYN_LANES-1:0]   sync_b;
  logic [`SYN_LANES-1:0]   sync_c;
  logic [1:0]              sys_div;

  counter_control_t        next_ctrl  [COUNTERS];
  logic [7:0]              next_count [COUNTERS];
  meas_state_t             next_meas  [COUNTERS];
  logic                    next_wprev [COUNTERS];
  logic                    hw_set     [COUNTERS];
  logic [3:0]              ovf_now;
  logic                    retrig_now;
  logic [3:0]              tick;
  logic                    src_tick;
  logic [`SYN_LANES-1:0]   rise;
  logic [`SYN_LANES-1:0]   fall;
  logic [`SYN_LANES-1:0]   ext_vec;
  logic                    restart_enable;

  assign restart_enable = counter3_control_b[`POS_RESTART_ENABLE];

  // ---------------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------------
  assign ext_vec = {i_ext.pattern_stopped, i_ext.pattern_output_disable,
                    i_ext.pattern_output_activation, i_ext.sub_clock,
                    i_ext.comparator0_pulse_event, i_ext.comparator0_level_output,
                    i_ext.timer1_ext_input_pin, i_ext.timer0_ext_input_pin};

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      sync_a <= '0;
      sync_b <= '0;
      sync_c <= '0;
    end else begin
      sync_a <= ext_vec;
      sync_b <= sync_a;
      sync_c <= sync_b;
    end
  end

  assign rise = sync_b & ~sync_c;
  assign fall = ~sync_b & sync_c;

  // ---------------------------------------------------------------------
  // prescaler input clock
  // ---------------------------------------------------------------------
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      sys_div <= 2'h0;
    end else begin
      sys_div <= sys_div + 2'h1;
    end
  end

  always_comb begin
    unique case (prescaler_control[1:0])
      `SRC_SYS:      src_tick = 1'b1;
      `SRC_SYS_DIV4: src_tick = (sys_div == 2'h3);
      `SRC_SYS_DIV2: src_tick = sys_div[0];
      `SRC_SUB:      src_tick = rise[`SYN_SUB_CLOCK];
    endcase
  end

  for (genvar g = 0; g < COUNTERS; g++) begin : g_div
    prescale_divider u_div (
      .i_clock       (i_clock),
      .i_rst_n       (i_rst_n),
      .i_source_tick (src_tick),
      .i_ratio       (ctrl[g].counter_prescale_ratio),
      .o_tick        (tick[g])
    );
  end

  // ---------------------------------------------------------------------
  // input selection
  // ---------------------------------------------------------------------
  function automatic int unsigned input_lane(input int idx, input logic ext_src);
    unique case (idx)
      0:       return ext_src ? `SYN_CMP_LEVEL : `SYN_PIN0;
      1:       return ext_src ? `SYN_CMP_PULSE : `SYN_PIN1;
      default: return ext_src ? `SYN_CMP_PULSE : `SYN_CMP_LEVEL;
    endcase
  endfunction

  function automatic logic is_active(input logic level, input logic edge_sel);
    return edge_sel ? level : ~level;
  endfunction

  // ---------------------------------------------------------------------
  // counter behaviour
  // ---------------------------------------------------------------------
  always_comb begin
    int unsigned lane;
    logic        lvl;
    logic        inc;
    logic        ev;
    ovf_now    = 4'h0;
    retrig_now = 1'b0;
    lane       = 0;
    lvl        = 1'b0;
    inc        = 1'b0;
    ev         = 1'b0;
    for (int i = 0; i < COUNTERS; i++) begin
      next_ctrl[i]  = ctrl[i];
      next_count[i] = count[i];
      next_meas[i]  = meas[i];
      hw_set[i]     = 1'b0;
      lane          = input_lane(i, ctrl[i].external_source_select);
      lvl           = sync_b[lane];
      next_wprev[i] = tick[i] ? lvl : wprev[i];
      inc           = 1'b0;
      ev            = ctrl[i].active_edge_select ? fall[lane] : rise[lane];
      if (lane == `SYN_CMP_PULSE) begin
        ev = rise[lane];
      end
      unique case (ctrl[i].op_select)
        `OP_WIDTH: begin
          if (i != 2 && ctrl[i].counter_run_enable) begin
            if (tick[i]) begin
              if (meas[i] == MEAS_ARMED) begin
                if (is_active(lvl, ctrl[i].active_edge_select) &&
                    !is_active(wprev[i], ctrl[i].active_edge_select)) begin
                  next_meas[i] = MEAS_RUNNING;
                end
              end else if (!is_active(lvl, ctrl[i].active_edge_select)) begin
                next_meas[i]                    = MEAS_ARMED;
                next_ctrl[i].counter_run_enable = 1'b0;
              end else begin
                inc = 1'b1;
              end
            end
          end else begin
            next_meas[i] = MEAS_ARMED;
          end
        end
        `OP_EVENT: begin
          inc = (i != 2) && ctrl[i].counter_run_enable && ev;
        end
        `OP_TIMER: begin
          inc = ctrl[i].counter_run_enable && tick[i];
        end
        `OP_PULSE_GEN: begin
          if (i == 2) begin
            if (rise[`SYN_PAT_STOPPED]) begin
              next_ctrl[i].counter_run_enable = 1'b1;
              hw_set[i]                       = 1'b1;
            end
            inc = ctrl[i].counter_run_enable && tick[i];
          end else if (i == 3) begin
            if (restart_enable && ctrl[i].counter_run_enable &&
                sync_b[`SYN_PAT_DISABLE]) begin
              next_ctrl[i].counter_run_enable = 1'b0;
            end else if (restart_enable && rise[`SYN_PAT_ACTIVE]) begin
              next_count[i]                   = preload[i];
              next_ctrl[i].counter_run_enable = 1'b1;
              hw_set[i]                       = !ctrl[i].counter_run_enable;
            end else begin
              inc = ctrl[i].counter_run_enable && tick[i];
            end
          end
        end
      endcase
      if (inc) begin
        if (count[i] == `COUNT_MAX) begin
          next_count[i] = preload[i];
          ovf_now[i]    = 1'b1;
          if (i == 2 && ctrl[i].op_select == `OP_PULSE_GEN) begin
            next_ctrl[i].counter_run_enable = 1'b0;
          end
          if (i == 3 && ctrl[i].op_select == `OP_PULSE_GEN && restart_enable) begin
            retrig_now = 1'b1;
          end
        end else begin
          next_count[i] = count[i] + 8'h01;
        end
      end
    end
  end

  // ---------------------------------------------------------------------
  // control registers
  // ---------------------------------------------------------------------
  function automatic logic [3:0] control_offset(input int idx);
    unique case (idx)
      0:       return `OFS_COUNTER0_CONTROL;
      1:       return `OFS_COUNTER1_CONTROL;
      2:       return `OFS_COUNTER2_CONTROL;
      default: return `OFS_COUNTER3_CONTROL_A;
    endcase
  endfunction

  function automatic logic [3:0] count_offset(input int idx);
    return 4'(`OFS_COUNTER0_COUNT + idx);
  endfunction

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      for (int i = 0; i < COUNTERS; i++) begin
        ctrl[i] <= counter_control_t'(`RST_CONTROL);
      end
    end else begin
      for (int i = 0; i < COUNTERS; i++) begin
        if (i_reg_req.write && i_reg_req.addr == control_offset(i)) begin
          ctrl[i] <= counter_control_t'(i_reg_req.wdata);
          if (hw_set[i]) begin
            ctrl[i].counter_run_enable <= 1'b1;
          end
        end else begin
          ctrl[i] <= next_ctrl[i];
        end
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      prescaler_control  <= `RST_PRESCALER;
      counter3_control_b <= `RST_CONTROL_B;
      request_enable     <= 4'(`RST_REQUEST_ENABLE);
    end else if (i_reg_req.write) begin
      unique case (i_reg_req.addr)
        `OFS_PRESCALER_CONTROL:  prescaler_control  <= {6'h00, i_reg_req.wdata[1:0]};
        `OFS_COUNTER3_CONTROL_B: counter3_control_b <= {7'h00, i_reg_req.wdata[0]};
        `OFS_REQUEST_ENABLE:     request_enable     <= i_reg_req.wdata[3:0];
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------------
  // counts, preloads and measurement state
  // ---------------------------------------------------------------------
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      for (int i = 0; i < COUNTERS; i++) begin
        count[i]   <= `RST_COUNT;
        preload[i] <= `RST_COUNT;
      end
    end else begin
      for (int i = 0; i < COUNTERS; i++) begin
        if (i_reg_req.write && i_reg_req.addr == count_offset(i)) begin
          preload[i] <= i_reg_req.wdata;
          if (!ctrl[i].counter_run_enable) begin
            count[i] <= i_reg_req.wdata;
          end else begin
            count[i] <= next_count[i];
          end
        end else begin
          count[i] <= next_count[i];
        end
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      for (int i = 0; i < COUNTERS; i++) begin
        meas[i]  <= MEAS_ARMED;
        wprev[i] <= 1'b0;
      end
    end else begin
      for (int i = 0; i < COUNTERS; i++) begin
        if (i_reg_req.write && i_reg_req.addr == control_offset(i)) begin
          meas[i] <= MEAS_ARMED;
        end else begin
          meas[i] <= next_meas[i];
        end
        wprev[i] <= next_wprev[i];
      end
    end
  end

  // ---------------------------------------------------------------------
  // requests and retrigger
  // ---------------------------------------------------------------------
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_overflow_request        <= 4'h0;
      o_timer_request           <= 4'h0;
      o_pattern_retrigger_pulse <= 1'b0;
    end else begin
      o_overflow_request        <= ovf_now;
      o_timer_request           <= ovf_now & request_enable;
      o_pattern_retrigger_pulse <= retrig_now;
    end
  end

  // ---------------------------------------------------------------------
  // read port
  // ---------------------------------------------------------------------
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_read_data <= 8'h00;
    end else if (i_reg_req.read) begin
      unique case (i_reg_req.addr)
        `OFS_PRESCALER_CONTROL:  o_read_data <= prescaler_control;
        `OFS_COUNTER0_CONTROL:   o_read_data <= ctrl[0];
        `OFS_COUNTER1_CONTROL:   o_read_data <= ctrl[1];
        `OFS_COUNTER2_CONTROL:   o_read_data <= ctrl[2];
        `OFS_COUNTER3_CONTROL_A: o_read_data <= ctrl[3];
        `OFS_COUNTER3_CONTROL_B: o_read_data <= counter3_control_b;
        `OFS_COUNTER0_COUNT:     o_read_data <= count[0];
        `OFS_COUNTER1_COUNT:     o_read_data <= count[1];
        `OFS_COUNTER2_COUNT:     o_read_data <= count[2];
        `OFS_COUNTER3_COUNT:     o_read_data <= count[3];
        `OFS_REQUEST_ENABLE:     o_read_data <= {4'h0, request_enable};
        `OFS_STATUS:             o_read_data <= {4'h0, meas[3] == MEAS_RUNNING,
                                                 1'b0, meas[1] == MEAS_RUNNING,
                                                 meas[0] == MEAS_RUNNING};
        default:                 o_read_data <= 8'h00;
      endcase
    end else begin
      o_read_data <= 8'h00;
    end
  end

endmodule

`default_nettype wire

// >>> sim/timer_chk.sv
/*
  Port checker for the pulse width and pattern retrigger timer.
  Assumes it is bound into the timer top and snoops register writes.
*/
`timescale 1ns/100ps
`default_nettype none
`include "timer_defines.svh"

module timer_chk
  import timer_pkg::*;
(
  input wire logic        i_clock,
  input wire logic        i_rst_n,
  input wire reg_req_t    i_reg_req,
  input wire logic [7:0]  o_read_data,
  input wire ext_inputs_t i_ext,
  input wire logic        o_pattern_retrigger_pulse,
  input wire logic [3:0]  o_overflow_request,
  input wire logic [3:0]  o_timer_request
);
  // ---------------------------------------------------------------
  // snooped configuration
  // ---------------------------------------------------------------
  logic       restart;
  logic [1:0] op3;
  logic [3:0] en;
  logic       cfg_ok;

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      restart <= 1'b0;
      op3     <= 2'h0;
      en      <= 4'h0;
    end else if (i_reg_req.write) begin
      if (i_reg_req.addr == `OFS_COUNTER3_CONTROL_B) restart <= i_reg_req.wdata[0];
      if (i_reg_req.addr == `OFS_COUNTER3_CONTROL_A) op3 <= i_reg_req.wdata[7:6];
      if (i_reg_req.addr == `OFS_REQUEST_ENABLE) en <= i_reg_req.wdata[3:0];
    end
  end
  assign cfg_ok = restart && (op3 == `OP_PULSE_GEN);

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);

  sequence s_disabled;
    i_ext.pattern_output_disable [*8];
  endsequence

  read_idle_a: assert property (!i_reg_req.read |=> o_read_data == 8'h00)
    else $error("read data not zero outside a read");
  unmapped_read_a: assert property (i_reg_req.read && i_reg_req.addr > `OFS_STATUS
    |=> o_read_data == 8'h00) else $error("unmapped read not zero");
  reset_quiet_a: assert property (disable iff (1'b0) !i_rst_n
    |=> (o_timer_request | o_overflow_request) == 4'h0 && !o_pattern_retrigger_pulse)
    else $error("request during reset");
  req_subset_a: assert property ((o_timer_request & ~o_overflow_request) == 4'h0)
    else $error("request without overflow");
  req_gate_a: assert property (!$past(i_reg_req.write && i_reg_req.addr == `OFS_REQUEST_ENABLE)
    |-> o_timer_request == (o_overflow_request & en)) else $error("request gating wrong");
  retrig_ovf_a: assert property (o_pattern_retrigger_pulse |-> o_overflow_request[3])
    else $error("retrigger without overflow");
  retrig_cfg_a: assert property (o_pattern_retrigger_pulse
    |-> $past(cfg_ok) || $past(cfg_ok, 2)) else $error("retrigger while restart off");
  disable_stop_a: assert property (s_disabled |=> !o_pattern_retrigger_pulse)
    else $error("retrigger while output disabled");
endmodule

bind pulse_width_and_pattern_retrigger_timer timer_chk chk (.i_clock(i_clock),
  .i_rst_n(i_rst_n), .i_reg_req(i_reg_req), .o_read_data(o_read_data), .i_ext(i_ext),
  .o_pattern_retrigger_pulse(o_pattern_retrigger_pulse),
  .o_overflow_request(o_overflow_request), .o_timer_request(o_timer_request));
`default_nettype wire

// >>> sim/timer_partner.sv
/*
  Far side of the timer: input pins, comparator lines and pattern generator.
  Assumes the bench calls set and fire from its clocked sequence only.
*/
`timescale 1ns/100ps
`default_nettype none

module timer_partner
  import timer_pkg::*;
(
  input  wire logic      i_clock,
  input  wire logic      i_retrigger,
  output var ext_inputs_t o_ext
);
  logic [2:0] sub_div;

  initial begin
    o_ext   = 8'h80;
    sub_div = 3'h0;
  end

  // ---------------------------------------------------------------
  // free running sub clock and generator restart
  // ---------------------------------------------------------------
  always @(posedge i_clock) begin
    sub_div         <= sub_div + 3'h1;
    o_ext.sub_clock <= sub_div[2];
  end

  always @(posedge i_clock) begin
    if (i_retrigger) fire();
  end

  task automatic set(input int lane, input logic v);
    @(posedge i_clock);
    o_ext[lane] <= v;
  endtask

  task automatic fire();
    repeat (3) @(posedge i_clock);
    o_ext.pattern_output_activation <= 1'b1;
    repeat (4) @(posedge i_clock);
    o_ext.pattern_output_activation <= 1'b0;
  endtask
endmodule
`default_nettype wire

// >>> sim/testbench.sv
/*
  Self-checking bench for the pulse width and pattern retrigger timer.
  Assumes timer_partner drives all external inputs.
*/
`timescale 1ns/100ps
`default_nettype none
`include "timer_defines.svh"

module testbench;
  import timer_pkg::*;
  logic        clock;
  logic        rst_n;
  reg_req_t    req;
  logic [7:0]  rdata;
  ext_inputs_t ext;
  logic        retrig;
  logic [3:0]  ovf;
  logic [3:0]  treq;
  int          err_count;
  int          n_tests;
  int          rtg_n;
  int          ovf_n [4] = '{default: 0};
  int          treq_n [4] = '{default: 0};

  pulse_width_and_pattern_retrigger_timer uut (.i_clock(clock), .i_rst_n(rst_n),
    .i_reg_req(req), .o_read_data(rdata), .i_ext(ext), .o_pattern_retrigger_pulse(retrig),
    .o_overflow_request(ovf), .o_timer_request(treq));
  timer_partner p (.i_clock(clock), .i_retrigger(retrig), .o_ext(ext));

  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  always @(posedge clock) begin
    for (int i = 0; i < 4; i++) begin
      if (ovf[i] === 1'b1) ovf_n[i]++;
      if (treq[i] === 1'b1) treq_n[i]++;
    end
    if (retrig === 1'b1) rtg_n++;
  end

  // ---------------------------------------------------------------
  // bus and check tasks
  // ---------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic cycles(input int n);
    repeat (n) @(posedge clock);
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    req.write <= 1'b1;
    req.addr  <= a;
    req.wdata <= d;
    @(posedge clock);
    req.write <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] exp, input string what);
    @(posedge clock);
    req.read <= 1'b1;
    req.addr <= a;
    @(posedge clock);
    req.read <= 1'b0;
    #1;
    check(what, exp, rdata);
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_regs();
    for (int a = 0; a < 16; a++) rd(4'(a), 8'h00, "reset value");
    wr(4'hE, 8'h5A);
    rd(4'hE, 8'h00, "unmapped");
    wr(`OFS_REQUEST_ENABLE, 8'h01);
    rd(`OFS_REQUEST_ENABLE, 8'h01, "request enable");
  endtask

  task automatic t_width(input logic [3:0] ctl, cnt, input int lane, idx, n, input logic idle,
                         input logic [7:0] c, pre, fin, input int novf, ntr);
    int o0;
    int t0;
    o0 = ovf_n[idx];
    t0 = treq_n[idx];
    wr(cnt, pre);
    wr(ctl, c);
    cycles(8);
    rd(cnt, pre, "armed count");
    p.set(lane, !idle);
    cycles(n - 1);
    p.set(lane, idle);
    cycles(8);
    rd(cnt, fin, "width count");
    rd(ctl, c & 8'hEF, "auto clear");
    check("overflows", novf, ovf_n[idx] - o0);
    check("requests", ntr, treq_n[idx] - t0);
    p.set(lane, !idle);
    cycles(5);
    p.set(lane, idle);
    cycles(8);
    rd(cnt, fin, "ignored edge");
  endtask

  task automatic t_timer();
    int o0;
    wr(`OFS_PRESCALER_CONTROL, 8'h02);
    wr(`OFS_COUNTER2_COUNT, 8'h00);
    o0 = ovf_n[2];
    wr(`OFS_COUNTER2_CONTROL, 8'h91);
    cycles(2100);
    check("timer overflows", 2, ovf_n[2] - o0);
    rd(`OFS_COUNTER2_CONTROL, 8'h91, "timer run kept");
    wr(`OFS_COUNTER2_CONTROL, 8'h00);
    wr(`OFS_PRESCALER_CONTROL, 8'h00);
    wr(`OFS_COUNTER2_COUNT, 8'h00);
    wr(`OFS_COUNTER2_CONTROL, 8'hD8);
    p.set(5, 1'b1);
    cycles(20);
    p.set(5, 1'b0);
    cycles(8);
    rd(`OFS_COUNTER2_COUNT, 8'h00, "no width on 2");
    rd(`OFS_COUNTER2_CONTROL, 8'hD8, "run kept on 2");
    wr(`OFS_COUNTER2_CONTROL, 8'h00);
  endtask

  task automatic t_pattern_stop();
    int o0;
    wr(`OFS_COUNTER2_COUNT, 8'hF0);
    o0 = ovf_n[2];
    p.set(0, 1'b1);
    cycles(2);
    p.set(0, 1'b0);
    cycles(300);
    check("single overflow", 1, ovf_n[2] - o0);
    rd(`OFS_COUNTER2_CONTROL, 8'h00, "run cleared");
    rd(`OFS_COUNTER2_COUNT, 8'hF0, "reloaded");
  endtask

  task automatic t_retrigger();
    int r0;
    wr(`OFS_COUNTER3_CONTROL_B, 8'h01);
    wr(`OFS_COUNTER3_COUNT, 8'hF8);
    wr(`OFS_COUNTER3_CONTROL_A, 8'h00);
    r0 = rtg_n;
    p.fire();
    cycles(3);
    rd(`OFS_COUNTER3_CONTROL_A, 8'h10, "started by output");
    cycles(100);
    check("retriggered", 1, rtg_n > r0);
    rd(`OFS_COUNTER3_CONTROL_A, 8'h10, "run kept");
    p.set(1, 1'b1);
    cycles(10);
    rd(`OFS_COUNTER3_CONTROL_A, 8'h00, "disabled");
    p.set(1, 1'b0);
    wr(`OFS_COUNTER3_CONTROL_B, 8'h00);
    r0 = rtg_n;
    p.fire();
    cycles(100);
    rd(`OFS_COUNTER3_CONTROL_A, 8'h00, "no action");
    check("no retrigger", 0, rtg_n - r0);
  endtask

  task automatic results();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // main sequence and watchdog
  // ---------------------------------------------------------------
  initial begin
    err_count = 0;
    n_tests   = 0;
    rtg_n     = 0;
    rst_n     = 1'b0;
    req       = '0;
    repeat (6) @(posedge clock);
    rst_n <= 1'b1;
    t_regs();
    t_width(`OFS_COUNTER0_CONTROL, `OFS_COUNTER0_COUNT, 7, 0, 30, 1'b1,
            8'hD0, 8'hF0, 8'hFD, 1, 1);
    t_width(`OFS_COUNTER1_CONTROL, `OFS_COUNTER1_COUNT, 6, 1, 20, 1'b0,
            8'hD8, 8'h00, 8'h13, 0, 0);
    t_width(`OFS_COUNTER3_CONTROL_A, `OFS_COUNTER3_COUNT, 5, 3, 12, 1'b0,
            8'hD8, 8'h00, 8'h0B, 0, 0);
    t_timer();
    t_pattern_stop();
    t_retrigger();
    results();
  end

  initial begin
    #1000000;
    err_count++;
    results();
  end
endmodule
`default_nettype wire
